// File: uss_sync_slave.v
// synchronous slave serial port with its control registers
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "uss_defines.vh"
module uss_sync_slave (
    input wire clock_i, // 125 MHz system clock
    input wire rst_i, // synchronous reset, active high
    input wire [1:0] addr_i, // register address
    input wire [7:0] wdata_i, // write data
    input wire wr_i, // write strobe
    input wire rd_i, // read strobe
    output reg [7:0] rdata_o, // read data, cycle after strobe
    input wire transmit_interrupt_enable_i, // transmit interrupt enable
    input wire receive_interrupt_enable_i, // receive interrupt enable
    output wire transmit_flag_o, // holding register empty
    output wire receive_flag_o, // receive buffer holds data
    output wire wake_irq_o, // enabled flag, wakes core
    input wire serial_clk_line_i, // shift clock pin in
    output wire serial_clk_line_o, // shift clock pin out
    output wire serial_clk_line_oe_n_o, // clock pin enable, low drives
    input wire serial_data_line_i, // data pin in
    output reg serial_data_line_o, // data pin out
    output wire serial_data_line_oe_n_o // data pin enable, low drives
);
    // -------------------------------------------------------------
    // control registers
    // -------------------------------------------------------------
    reg [7:0] rc_q; // upper control bits of receive control
    reg [7:0] tc_q; // writable bits of transmit control
    reg overrun_error_flag_q;
    wire port_en = rc_q[`USS_RC_PORT_EN];
    wire clocked = tc_q[`USS_TC_CLOCKED];
    wire cont_rx = rc_q[`USS_RC_CONT];
    wire slave = port_en && clocked && !tc_q[`USS_TC_CLK_SRC];
    wire mod_rst = rst_i || !port_en;
    wire rx_active = slave && cont_rx;
    wire tx_active = slave && tc_q[`USS_TC_XMT_EN] && !rx_active;
    // -------------------------------------------------------------
    // pin synchronisers and clock edge detect
    // -------------------------------------------------------------
    reg [1:0] ck_s_q;
    reg [1:0] dt_s_q;
    reg ck_prev_q;
    always @(posedge clock_i) begin
        if (rst_i) begin
            ck_s_q <= 2'b00;
            dt_s_q <= 2'b00;
            ck_prev_q <= 1'b0;
        end else begin
            ck_s_q <= {ck_s_q[0], serial_clk_line_i};
            dt_s_q <= {dt_s_q[0], serial_data_line_i};
            ck_prev_q <= ck_s_q[1];
        end
    end
    // edges of the external clock, core sleep irrelevant
    wire ck_fall = ck_prev_q && !ck_s_q[1];
    wire ck_rise = !ck_prev_q && ck_s_q[1];
    // -------------------------------------------------------------
    // transmitter
    // -------------------------------------------------------------
    reg [8:0] hold_q;
    reg hold_full_q;
    reg [8:0] tsr_q;
    reg [3:0] tx_cnt_q;
    reg tx_busy_q;
    wire hold_wr = wr_i && (addr_i == `USS_ADDR_XMT_HOLD);
    wire [3:0] tx_len = tc_q[`USS_TC_NINE] ? `USS_BITS_9 : `USS_BITS_8;
    always @(posedge clock_i) begin
        if (mod_rst || !tc_q[`USS_TC_XMT_EN]) begin
            hold_full_q <= 1'b0;
            hold_q <= 9'h000;
            tsr_q <= 9'h000;
            tx_cnt_q <= 4'h0;
            tx_busy_q <= 1'b0;
            serial_data_line_o <= 1'b0;
        end else begin
            if (hold_wr) begin
                hold_q <= {tc_q[`USS_TC_NINTH], wdata_i};
                hold_full_q <= 1'b1;
            end
            // holding word moves on once shifter is empty
            if (!tx_busy_q && hold_full_q && tx_active) begin
                tsr_q <= hold_q;
                tx_cnt_q <= tx_len;
                tx_busy_q <= 1'b1;
                if (!hold_wr)
                    hold_full_q <= 1'b0;
            end else if (tx_busy_q && tx_active && ck_rise) begin
                // bit changes on rising edge, stable at falling
                serial_data_line_o <= tsr_q[0];
                tsr_q <= {1'b0, tsr_q[8:1]};
                tx_cnt_q <= tx_cnt_q - 4'h1;
            end else if (tx_busy_q && tx_cnt_q == 4'h0 && ck_fall) begin
                tx_busy_q <= 1'b0;
            end
        end
    end
    // data pin driven only while transmitting
    assign serial_data_line_oe_n_o = !(tx_active && tx_busy_q);
    // clock pin never driven in slave mode
    assign serial_clk_line_oe_n_o = 1'b1;
    assign serial_clk_line_o = 1'b0;
    wire tx_idle = !tx_busy_q;
    // -------------------------------------------------------------
    // receiver
    // -------------------------------------------------------------
    reg [8:0] rsr_q;
    reg [3:0] rx_cnt_q;
    reg push_q;
    reg [9:0] push_data_q;
    wire fifo_full;
    wire fifo_empty;
    wire [9:0] fifo_head;
    wire buf_rd = rd_i && (addr_i == `USS_ADDR_RCV_BUF);
    wire [3:0] rx_len = rc_q[`USS_RC_NINE] ? `USS_BITS_9 : `USS_BITS_8;
    wire [3:0] rx_next = rx_cnt_q + 4'h1;
    wire [8:0] rx_word = rc_q[`USS_RC_NINE] ? {dt_s_q[1], rsr_q[8:1]} :
                         {1'b0, dt_s_q[1], rsr_q[8:2]};
    always @(posedge clock_i) begin
        if (mod_rst || !rx_active) begin
            rsr_q <= 9'h000;
            rx_cnt_q <= 4'h0;
            push_q <= 1'b0;
            push_data_q <= 10'h000;
        end else begin
            push_q <= 1'b0;
            if (ck_fall) begin
                rsr_q <= {dt_s_q[1], rsr_q[8:1]};
                if (rx_next == rx_len) begin
                    rx_cnt_q <= 4'h0;
                    // address detect in 9-bit mode only
                    if (!(rc_q[`USS_RC_NINE] && rc_q[`USS_RC_ADDR_DET]
                          && !rx_word[8]) && !overrun_error_flag_q) begin
                        push_q <= 1'b1;
                        // framing error has no stop bit here
                        push_data_q <= {1'b0, rx_word};
                    end
                end else begin
                    rx_cnt_q <= rx_next;
                end
            end
        end
    end
    // overrun set, cleared by clearing continuous receive
    always @(posedge clock_i) begin
        if (mod_rst || !cont_rx)
            overrun_error_flag_q <= 1'b0;
        // third word with buffer full is lost
        else if (push_q && fifo_full && !buf_rd)
            overrun_error_flag_q <= 1'b1;
    end
    // word moves into the two-deep buffer
    uss_rx_fifo u_fifo (
        .clock_i(clock_i),
        .clr_i(mod_rst),
        .push_i(push_q && !overrun_error_flag_q),
        .din_i(push_data_q),
        .pop_i(buf_rd),
        .dout_o(fifo_head),
        .empty_o(fifo_empty),
        .full_o(fifo_full)
    );
    // -------------------------------------------------------------
    // flags and wake interrupt
    // -------------------------------------------------------------
    assign transmit_flag_o = !hold_full_q;
    assign receive_flag_o = !fifo_empty;
    assign wake_irq_o = (transmit_flag_o && transmit_interrupt_enable_i &&
                         tx_active) ||
                        (receive_flag_o && receive_interrupt_enable_i);
    // -------------------------------------------------------------
    // register writes and reads
    // -------------------------------------------------------------
    always @(posedge clock_i) begin
        if (rst_i) begin
            rc_q <= 8'h00;
            tc_q <= 8'h00;
        end else if (wr_i && addr_i == `USS_ADDR_RCV_CTRL) begin
            rc_q <= wdata_i & `USS_RC_WR_MASK;
        end else if (wr_i && addr_i == `USS_ADDR_XMT_CTRL) begin
            // bit 3 unimplemented; speed bit stored, unused
            tc_q <= wdata_i & `USS_TC_WR_MASK;
        end else if (!clocked || slave) begin
            // single receive only counts in master mode
            rc_q[`USS_RC_SINGLE] <= rc_q[`USS_RC_SINGLE];
        end
    end
    reg [7:0] rd_d;
    always @* begin
        rd_d = 8'h00;
        case (addr_i)
            `USS_ADDR_RCV_CTRL: begin
                rd_d = rc_q;
                // framing error; ninth bit from buffer head
                rd_d[`USS_RC_FRAMING_ERROR_FLAG] = fifo_head[9];
                rd_d[`USS_RC_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
                // empty buffer shows no stale ninth bit
                rd_d[`USS_RC_NINTH] = fifo_head[8] && !fifo_empty;
            end
            `USS_ADDR_XMT_CTRL: begin
                rd_d = tc_q;
                rd_d[`USS_TC_IDLE] = tx_idle;
            end
            `USS_ADDR_RCV_BUF: rd_d = fifo_head[7:0];
            default: rd_d = 8'h00;
        endcase
    end
    always @(posedge clock_i) begin
        if (rst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= rd_d;
        else
            rdata_o <= 8'h00;
    end
endmodule // uss_sync_slave
`default_nettype wire

// File: uss_defines.vh
// constants for the synchronous slave serial port
// Operation
// - clocked mode with clock source clear makes port slave on external clock
// - slave keeps shifting during core sleep using the external clock
// - second holding word waits until first leaves shift register
// - slave transmit raises wake interrupt when transmit interrupt enabled
// - completed slave word moves to buffer and raises receive wake interrupt
// - single receive enable ignored in slave and asynchronous modes
// - port enable assigns pins; cleared holds module in reset
// - receive nine-bit select chooses 9-bit or 8-bit reception
// - master single receive takes one word then clears itself
// - continuous receive runs until cleared and beats single receive
// - address detect loads only words with ninth bit set in 9-bit mode
// - framing error flag refreshed with buffer read and next word
// - overrun flag sets on overrun, cleared only by clearing continuous receive; here clearing port enable also clears it
// - bit 0 of receive control shows ninth received bit
// - port switches pins between released and driven by itself
// - transmit nine-bit select chooses width; bit 0 gives ninth bit
// - active receive enable overrides transmit enable in clocked mode
// - mode select bit 4 picks clocked mode; bit 3 reads zero
// - high speed baud select ignored in clocked mode
// - transmit idle bit reads 1 when idle, resets to 1
// - incoming data sampled at falling edge of shift clock
// - transmitted data stable around falling edge of shift clock
// - receive buffer two deep; third word with buffer full is overrun
`ifndef USS_DEFINES_VH
`define USS_DEFINES_VH
`define USS_ADDR_RCV_CTRL 2'h0
`define USS_ADDR_XMT_CTRL 2'h1
`define USS_ADDR_XMT_HOLD 2'h2
`define USS_ADDR_RCV_BUF 2'h3
`define USS_RC_PORT_EN 7
`define USS_RC_NINE 6
`define USS_RC_SINGLE 5
`define USS_RC_CONT 4
`define USS_RC_ADDR_DET 3
`define USS_RC_FRAMING_ERROR_FLAG 2
`define USS_RC_OVERRUN_ERROR_FLAG 1
`define USS_RC_NINTH 0
`define USS_TC_CLK_SRC 7
`define USS_TC_NINE 6
`define USS_TC_XMT_EN 5
`define USS_TC_CLOCKED 4
`define USS_TC_HI_SPEED 2
`define USS_TC_IDLE 1
`define USS_TC_NINTH 0
`define USS_RC_WR_MASK 8'hF8
`define USS_TC_WR_MASK 8'hF5
`define USS_BITS_8 4'h8
`define USS_BITS_9 4'h9
`endif

// File: uss_rx_fifo.v
// two-entry receive buffer holding data, ninth bit and framing error
`timescale 1ns/1ns
`default_nettype none
module uss_rx_fifo (
    input wire clock_i, // system clock
    input wire clr_i, // synchronous clear
    input wire push_i, // write one entry
    input wire [9:0] din_i, // {framing_error_flag, ninth, data}
    input wire pop_i, // read one entry
    output wire [9:0] dout_o, // head entry
    output wire empty_o, // no entry
    output wire full_o // two entries
);
    reg [9:0] mem_q [0:1];
    reg rd_q;
    reg wr_q;
    reg [1:0] cnt_q;
    wire do_push;
    wire do_pop;
    assign do_pop = pop_i && (cnt_q != 2'h0);
    // a pop in the same cycle frees the slot the push needs
    assign do_push = push_i && ((cnt_q != 2'h2) || do_pop);
    assign dout_o = mem_q[rd_q];
    assign empty_o = (cnt_q == 2'h0);
    assign full_o = (cnt_q == 2'h2);
    always @(posedge clock_i) begin
        if (clr_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
            mem_q[0] <= 10'h000;
            mem_q[1] <= 10'h000;
        end else begin
            if (do_push) begin
                mem_q[wr_q] <= din_i;
                wr_q <= ~wr_q;
            end
            if (do_pop)
                rd_q <= ~rd_q;
            if (do_push && !do_pop)
                cnt_q <= cnt_q + 2'h1;
            else if (do_pop && !do_push)
                cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule // uss_rx_fifo
`default_nettype wire

// File: uss_sync_slave_properties.sv
// assertion checker for the synchronous slave serial port
`timescale 1ns/1ns
`default_nettype none
`include "uss_defines.vh"
module uss_sync_slave_chk (
    input wire logic clock_i, // clock
    input wire logic rst_i, // reset
    input wire logic [1:0] addr_i, // address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write
    input wire logic rd_i, // read
    input wire logic [7:0] rdata_o, // read data
    input wire logic transmit_interrupt_enable_i, // tx enable
    input wire logic receive_interrupt_enable_i, // rx enable
    input wire logic transmit_flag_o, // holding empty
    input wire logic receive_flag_o, // buffer data
    input wire logic wake_irq_o, // wake
    input wire logic serial_clk_line_i, // clock pin
    input wire logic serial_clk_line_oe_n_o, // clock enable
    input wire logic serial_data_line_o, // data out
    input wire logic serial_data_line_oe_n_o // data enable
);
    // ----------------------------------------
    // pin, flag and register relations
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_clk_free; serial_clk_line_oe_n_o; endproperty
    a_clk_free: assert property (p_clk_free)
        else $error("clock pin driven");
    property p_dat_hold;
        $fell(serial_clk_line_i) && !serial_data_line_oe_n_o
            |-> ($stable(serial_data_line_o) || serial_data_line_oe_n_o) [*5];
    endproperty
    a_dat_hold: assert property (p_dat_hold)
        else $error("data moved at clock fall");
    property p_rx_wake;
        receive_flag_o && receive_interrupt_enable_i |-> wake_irq_o;
    endproperty
    a_rx_wake: assert property (p_rx_wake)
        else $error("receive wake missing");
    property p_wake_cause;
        wake_irq_o |-> (receive_flag_o && receive_interrupt_enable_i)
            || (transmit_flag_o && transmit_interrupt_enable_i);
    endproperty
    a_wake_cause: assert property (p_wake_cause)
        else $error("wake without cause");
    property p_gap_bit;
        rd_i && addr_i == `USS_ADDR_XMT_CTRL |=> !rdata_o[3];
    endproperty
    a_gap_bit: assert property (p_gap_bit)
        else $error("unused bit reads one");
    property p_no_framing_error_flag;
        rd_i && addr_i == `USS_ADDR_RCV_CTRL |=> !rdata_o[2];
    endproperty
    a_no_framing_error_flag: assert property (p_no_framing_error_flag)
        else $error("framing flag set");
    property p_hold_load;
        $fell(transmit_flag_o) |-> $past(wr_i)
            && $past(addr_i) == `USS_ADDR_XMT_HOLD;
    endproperty
    a_hold_load: assert property (p_hold_load)
        else $error("holding flag fell without write");
    property p_buf_pop;
        $fell(receive_flag_o) |-> $past(rd_i)
            && $past(addr_i) == `USS_ADDR_RCV_BUF || $past(wr_i);
    endproperty
    a_buf_pop: assert property (p_buf_pop)
        else $error("receive flag fell without read");
    property p_port_off;
        wr_i && addr_i == `USS_ADDR_RCV_CTRL && !wdata_i[7]
            |=> ##1 (!receive_flag_o && serial_data_line_oe_n_o) [*2];
    endproperty
    a_port_off: assert property (p_port_off)
        else $error("disabled port still active");
endmodule // uss_sync_slave_chk
bind uss_sync_slave uss_sync_slave_chk uss_sync_slave_chk_i (.*);
`default_nettype wire

// File: uss_ext_master.sv
// external master that supplies the shift clock
`timescale 1ns/1ns
`default_nettype none
module uss_ext_master (
    output logic clk_o, // shift clock, low between frames
    output logic dat_o, // data offered to the line
    input wire logic dat_i // resolved data line
);
    initial begin
        clk_o = 1'h0;
        dat_o = 1'h0;
    end
    // ----------------------------------------
    // one frame, LSB first; drv low lets the device talk
    // ----------------------------------------
    task automatic xfer(input logic [8:0] w, input int n, input logic drv,
                        output logic [8:0] r);
        r = 9'h000;
        for (int k = 0; k < n; k++) begin
            #31 dat_o = drv ? w[k] : ~dat_o;
            #32 clk_o = 1'h1;
            #62 r[k] = dat_i;
            clk_o = 1'h0;
        end
        // released line no longer shows the last bit
        #31 dat_o = ~dat_o;
    endtask
endmodule // uss_ext_master
`default_nettype wire

// File: tb.sv
// self-checking bench for the synchronous slave serial port
`timescale 1ns/1ns
`default_nettype none
`include "uss_defines.vh"
module tb;
    logic clock_i, rst_i, wr_i, rd_i;
    logic [1:0] addr_i;
    logic [7:0] wdata_i, rv;
    logic transmit_interrupt_enable_i, receive_interrupt_enable_i;
    logic [8:0] got;
    logic ld;
    wire [7:0] rdata_o;
    wire transmit_flag_o, receive_flag_o, wake_irq_o, mst_dat;
    wire serial_clk_line_i, serial_clk_line_o, serial_clk_line_oe_n_o;
    wire serial_data_line_i, serial_data_line_o, serial_data_line_oe_n_o;
    int err_total = 0;
    int check_count = 0;
    logic [7:0] row_ctl [7] = '{8'h90, 8'hD0, 8'hD8, 8'hD8, 8'h98, 8'hA0, 8'h10};
    logic [8:0] row_word [7] = '{9'h0A5, 9'h13C, 9'h0C3, 9'h1E7, 9'h05A,
                                 9'h0FF, 9'h0FF};
    assign serial_data_line_i = serial_data_line_oe_n_o ? mst_dat
                                                        : serial_data_line_o;
    uss_sync_slave uss_sync_slave_i (.*);
    uss_ext_master uss_ext_master_i (.clk_o(serial_clk_line_i),
        .dat_o(mst_dat), .dat_i(serial_data_line_i));
    initial begin
        clock_i = 1'h0;
        forever #4 clock_i = ~clock_i;
    end
    // ----------------------------------------
    // bus, compare and closing tasks
    // ----------------------------------------
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'h1;
        @(posedge clock_i);
        wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge clock_i);
        rd_i <= 1'h0;
        #1 d = rdata_o;
    endtask
    task automatic reset_dut;
        @(posedge clock_i);
        rst_i <= 1'h1;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'h0;
    endtask
    task automatic give_verdict;
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        err_total++;
        give_verdict;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_i, wr_i, rd_i, addr_i, wdata_i} = 13'h1000;
        {transmit_interrupt_enable_i, receive_interrupt_enable_i} = 2'h3;
        reset_dut;
        rd(`USS_ADDR_XMT_CTRL, rv);
        chk(rv, 8'h02);
        chk(transmit_flag_o, 1'h1);
        wr(`USS_ADDR_XMT_CTRL, 8'hFF);
        rd(`USS_ADDR_XMT_CTRL, rv);
        chk(rv, 8'hF7);
        wr(`USS_ADDR_RCV_CTRL, 8'hFF);
        rd(`USS_ADDR_RCV_CTRL, rv);
        chk(rv, 8'hF8);
        wr(`USS_ADDR_XMT_CTRL, 8'h10);
        for (int i = 0; i < 7; i++) begin
            ld = row_ctl[i][7] && row_ctl[i][4]
                && !(row_ctl[i][6] && row_ctl[i][3] && !row_word[i][8]);
            wr(`USS_ADDR_RCV_CTRL, row_ctl[i]);
            uss_ext_master_i.xfer(row_word[i], row_ctl[i][6] ? 9 : 8, 1'h1, got);
            repeat (10) @(negedge clock_i);
            chk(receive_flag_o, ld);
            chk(wake_irq_o, ld);
            rd(`USS_ADDR_RCV_CTRL, rv);
            chk(rv, row_ctl[i] | (ld & row_ctl[i][6] & row_word[i][8]));
            rd(`USS_ADDR_RCV_BUF, rv);
            if (ld) chk(rv, row_word[i][7:0]);
        end
        wr(`USS_ADDR_RCV_CTRL, 8'h90);
        for (int i = 0; i < 4; i++) begin
            uss_ext_master_i.xfer(9'h011 << i, 8, 1'h1, got);
        end
        repeat (10) @(negedge clock_i);
        rd(`USS_ADDR_RCV_CTRL, rv);
        chk(rv, 8'h92);
        rd(`USS_ADDR_RCV_BUF, rv);
        chk(rv, 8'h11);
        rd(`USS_ADDR_RCV_BUF, rv);
        chk(rv, 8'h22);
        chk(receive_flag_o, 1'h0);
        rd(`USS_ADDR_RCV_CTRL, rv);
        chk(rv, 8'h92);
        wr(`USS_ADDR_RCV_CTRL, 8'h80);
        rd(`USS_ADDR_RCV_CTRL, rv);
        chk(rv, 8'h80);
        wr(`USS_ADDR_RCV_CTRL, 8'h90);
        uss_ext_master_i.xfer(9'h066, 8, 1'h1, got);
        repeat (10) @(negedge clock_i);
        rd(`USS_ADDR_RCV_BUF, rv);
        chk(rv, 8'h66);
        // slave transmit set up in the documented software order
        wr(`USS_ADDR_RCV_CTRL, 8'h80);
        wr(`USS_ADDR_XMT_CTRL, 8'h71);
        wr(`USS_ADDR_XMT_HOLD, 8'h3C);
        wr(`USS_ADDR_XMT_HOLD, 8'hA5);
        @(negedge clock_i);
        chk(transmit_flag_o, 1'h0);
        chk(wake_irq_o, 1'h0);
        chk(serial_data_line_oe_n_o, 1'h0);
        rd(`USS_ADDR_XMT_CTRL, rv);
        chk(rv, 8'h71);
        uss_ext_master_i.xfer(9'h000, 9, 1'h0, got);
        chk(got, 9'h13C);
        repeat (10) @(negedge clock_i);
        chk(transmit_flag_o, 1'h1);
        chk(wake_irq_o, 1'h1);
        uss_ext_master_i.xfer(9'h000, 9, 1'h0, got);
        chk(got, 9'h1A5);
        repeat (10) @(negedge clock_i);
        chk(serial_data_line_oe_n_o, 1'h1);
        rd(`USS_ADDR_XMT_CTRL, rv);
        chk(rv, 8'h73);
        wr(`USS_ADDR_RCV_CTRL, 8'h90);
        wr(`USS_ADDR_XMT_HOLD, 8'h55);
        repeat (4) @(negedge clock_i);
        chk(serial_data_line_oe_n_o, 1'h1);
        reset_dut;
        rd(`USS_ADDR_XMT_CTRL, rv);
        chk(rv, 8'h02);
        give_verdict;
    end
endmodule // tb
`default_nettype wire
